// *** src/tcct_prescaler.v ***
// Bus clock prescaler that yields one tick pulse per divided period.
// Assumes divide settings come from registers in the same clock domain.
module tcct_prescaler (
  input  wire       clk,
  input  wire       rst,
  input  wire       run,
  input  wire       prec_mode,
  input  wire [2:0] coarse_sel,
  input  wire [7:0] prec_val,
  output reg        tick
);

  reg [7:0] cnt_r;
  reg [7:0] limit_r;
  wire [7:0] limit_nxt;

  // Terminal count for the requested divider
  assign limit_nxt = prec_mode ? prec_val : ((8'h01 << coarse_sel) - 8'h01);

  // Counter stages; new limit loaded while stopped or when stages are zero
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_r   <= 8'h00;
      limit_r <= 8'h00;
      tick    <= 1'b0;
    end
    else if (!run)
    begin
      cnt_r   <= 8'h00;
      limit_r <= limit_nxt;
      tick    <= 1'b0;
    end
    else
    begin
      tick <= (cnt_r == limit_r);
      if (cnt_r == limit_r)
        cnt_r <= 8'h00;
      else
        cnt_r <= cnt_r + 8'h01;
      if (cnt_r == 8'h00)
        limit_r <= limit_nxt;
    end
  end

endmodule // tcct_prescaler

// *** src/tcct_regs.vh ***
// Register offsets, field positions and reset values of the two-channel timer.
// Assumes a 32-bit APB slave; each register sits in one aligned word.
`ifndef TCCT_REGS_VH
`define TCCT_REGS_VH

// Byte addresses
`define TCCT_CTRL1_ADDR   12'h000
`define TCCT_CTRL2_ADDR   12'h004
`define TCCT_PDIV_ADDR    12'h008
`define TCCT_DIR_ADDR     12'h00c
`define TCCT_FORCE_ADDR   12'h010
`define TCCT_OCMODE_ADDR  12'h014
`define TCCT_EDGE_ADDR    12'h018
`define TCCT_IEN_ADDR     12'h01c
`define TCCT_FLAG1_ADDR   12'h020
`define TCCT_FLAG2_ADDR   12'h024
`define TCCT_CNT_ADDR     12'h028
`define TCCT_CH0_ADDR     12'h02c
`define TCCT_CH1_ADDR     12'h030
`define TCCT_DISC_ADDR    12'h034
`define TCCT_PORT_ADDR    12'h038

// Field positions
`define TCCT_RUN_BIT      7
`define TCCT_PREC_BIT     3
`define TCCT_OVIE_BIT     7
`define TCCT_WRAP_BIT     7

// Reset values and counter maximum
`define TCCT_CNT_RST      16'h0000
`define TCCT_CH_RST       16'h0000
`define TCCT_CNT_MAX      16'hffff

`endif

// *** src/tcct_timer.v ***
// Two-channel 16-bit capture/compare timer with an APB register slave.
// Assumes pins are asynchronous to clk; APB master on clk.
`include "tcct_regs.vh"

module tcct_timer (
  input  wire        clk,
  input  wire        rst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire [1:0]  capture_in,
  output reg  [1:0]  pin_out,
  output reg  [1:0]  pin_oe_n,
  output reg  [1:0]  channel_irq,
  output reg         wrap_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  reg        timer_run_enable_r;
  reg        precision_divide_mode_r;
  reg        wrap_irq_en_r;
  reg [2:0]  coarse_divide_select_r;
  reg [7:0]  precision_divide_value_r;
  reg [1:0]  channel_direction_bit_r;
  reg [1:0]  compare_mode_bit_r;
  reg [1:0]  compare_level_bit_r;
  reg [1:0]  edge_select_high_r;
  reg [1:0]  edge_select_low_r;
  reg [1:0]  channel_irq_enable_r;
  reg [1:0]  channel_event_flag_r;
  reg        counter_wrap_flag_r;
  reg        cnt_step_r;
  reg [15:0] count_r;
  reg [15:0] chan_val_r [0:1];
  reg [1:0]  pin_disconnect_bit_r;
  reg [1:0]  port_data_r;
  reg [1:0]  port_dir_r;
  reg [1:0]  oc_out_r;
  reg [1:0]  sync1_r;
  reg [1:0]  sync2_r;
  reg [1:0]  sync3_r;
  reg [31:0] rdata_nxt;
  reg        known_nxt;

  wire       tick;
  wire       wr_en;
  wire       rd_en;
  wire [1:0] cap_hit;
  wire [1:0] cmp_hit;
  wire [1:0] force_hit;
  wire [1:0] flag_clr;
  wire       wrap_hit;
  wire       wrap_clr;

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler
  tcct_prescaler u_presc (
    .clk        (clk),
    .rst        (rst),
    .run        (timer_run_enable_r),
    .prec_mode  (precision_divide_mode_r),
    .coarse_sel (coarse_divide_select_r),
    .prec_val   (precision_divide_value_r),
    .tick       (tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // APB strobes: zero wait state, write at access phase
  assign wr_en = psel & penable & pwrite & pready;
  assign rd_en = psel & ~penable & ~pwrite;

  // Flag clears need the timer running
  assign flag_clr = (wr_en && paddr == `TCCT_FLAG1_ADDR && timer_run_enable_r) ? pwdata[1:0] : 2'b00;
  assign wrap_clr = wr_en && paddr == `TCCT_FLAG2_ADDR && timer_run_enable_r
                    && pwdata[`TCCT_WRAP_BIT];
  assign wrap_hit = timer_run_enable_r && tick && (count_r == `TCCT_CNT_MAX);
  assign force_hit = (wr_en && paddr == `TCCT_FORCE_ADDR) ? pwdata[1:0] : 2'b00;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; first stage feeds only the second
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sync1_r <= 2'b00;
      sync2_r <= 2'b00;
      sync3_r <= 2'b00;
    end
    else
    begin
      sync1_r <= capture_in;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel capture, compare and output logic
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : g_chan
      wire rise;
      wire fall;
      wire act;
      // Edge detection after the synchroniser
      assign rise = sync2_r[g] & ~sync3_r[g];
      assign fall = ~sync2_r[g] & sync3_r[g];
      assign cap_hit[g] = ~channel_direction_bit_r[g] & ((edge_select_low_r[g] & rise) |
                          (edge_select_high_r[g] & fall));
      // Match only in the first cycle of a new count, so one action per value
      assign cmp_hit[g] = channel_direction_bit_r[g] & timer_run_enable_r & cnt_step_r &
                          (count_r == chan_val_r[g]);
      assign act = (cmp_hit[g] | force_hit[g]) & channel_direction_bit_r[g];

      // Internal compare output register
      always @(posedge clk or posedge rst)
      begin
        if (rst)
          oc_out_r[g] <= 1'b0;
        else if (act)
        begin
          case ({compare_mode_bit_r[g], compare_level_bit_r[g]})
            2'b01:   oc_out_r[g] <= ~oc_out_r[g];
            2'b10:   oc_out_r[g] <= 1'b0;
            2'b11:   oc_out_r[g] <= 1'b1;
            default: oc_out_r[g] <= oc_out_r[g];
          endcase
        end
      end

      // Pin drive: timer output or latched port data
      always @(posedge clk or posedge rst)
      begin
        if (rst)
        begin
          pin_out[g]  <= 1'b0;
          pin_oe_n[g] <= 1'b1;
        end
        else if (channel_direction_bit_r[g] && !pin_disconnect_bit_r[g] &&
                 (compare_mode_bit_r[g] || compare_level_bit_r[g]))
        begin
          pin_out[g]  <= oc_out_r[g];
          pin_oe_n[g] <= 1'b0;
        end
        else
        begin
          pin_out[g]  <= port_data_r[g];
          pin_oe_n[g] <= ~port_dir_r[g];
        end
      end

      // Channel flag; set wins over clear
      always @(posedge clk or posedge rst)
      begin
        if (rst)
          channel_event_flag_r[g] <= 1'b0;
        else if (cap_hit[g] || cmp_hit[g])
          channel_event_flag_r[g] <= 1'b1;
        else if (flag_clr[g])
          channel_event_flag_r[g] <= 1'b0;
      end

      // Capture or software write of channel value
      always @(posedge clk or posedge rst)
      begin
        if (rst)
          chan_val_r[g] <= `TCCT_CH_RST;
        else if (cap_hit[g])
          chan_val_r[g] <= count_r;
        else if (wr_en && channel_direction_bit_r[g] &&
                 paddr == (g == 0 ? `TCCT_CH0_ADDR : `TCCT_CH1_ADDR))
          chan_val_r[g] <= pwdata[15:0];
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Free-running counter and overflow flag
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      count_r             <= `TCCT_CNT_RST;
      counter_wrap_flag_r <= 1'b0;
      cnt_step_r          <= 1'b0;
    end
    else
    begin
      cnt_step_r <= timer_run_enable_r && tick; // Marks a freshly advanced count
      if (timer_run_enable_r && tick)
        count_r <= count_r + 16'h0001;
      if (wrap_hit)
        counter_wrap_flag_r <= 1'b1;
      else if (wrap_clr)
        counter_wrap_flag_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt outputs: flag AND enable, registered
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      channel_irq <= 2'b00;
      wrap_irq    <= 1'b0;
    end
    else
    begin
      channel_irq <= channel_event_flag_r & channel_irq_enable_r;
      wrap_irq    <= counter_wrap_flag_r & wrap_irq_en_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register writes
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      timer_run_enable_r       <= 1'b0;
      precision_divide_mode_r  <= 1'b0;
      wrap_irq_en_r            <= 1'b0;
      coarse_divide_select_r   <= 3'h0;
      precision_divide_value_r <= 8'h00;
      channel_direction_bit_r  <= 2'b00;
      compare_mode_bit_r       <= 2'b00;
      compare_level_bit_r      <= 2'b00;
      edge_select_high_r       <= 2'b00;
      edge_select_low_r        <= 2'b00;
      channel_irq_enable_r     <= 2'b00;
      pin_disconnect_bit_r     <= 2'b00;
      port_data_r              <= 2'b00;
      port_dir_r               <= 2'b00;
    end
    else if (wr_en)
    begin
      case (paddr)
        `TCCT_CTRL1_ADDR:
        begin
          timer_run_enable_r      <= pwdata[`TCCT_RUN_BIT];
          precision_divide_mode_r <= pwdata[`TCCT_PREC_BIT];
        end
        `TCCT_CTRL2_ADDR:
        begin
          wrap_irq_en_r          <= pwdata[`TCCT_OVIE_BIT];
          coarse_divide_select_r <= pwdata[2:0];
        end
        `TCCT_PDIV_ADDR:   precision_divide_value_r <= pwdata[7:0];
        `TCCT_DIR_ADDR:    channel_direction_bit_r  <= pwdata[1:0];
        `TCCT_OCMODE_ADDR:
        begin
          compare_level_bit_r <= pwdata[1:0];
          compare_mode_bit_r  <= pwdata[9:8];
        end
        `TCCT_EDGE_ADDR:
        begin
          edge_select_low_r  <= pwdata[1:0];
          edge_select_high_r <= pwdata[9:8];
        end
        `TCCT_IEN_ADDR:    channel_irq_enable_r <= pwdata[1:0];
        `TCCT_DISC_ADDR:   pin_disconnect_bit_r <= pwdata[1:0];
        `TCCT_PORT_ADDR:
        begin
          port_data_r <= pwdata[1:0];
          port_dir_r  <= pwdata[9:8];
        end
        default: port_dir_r <= port_dir_r;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux
  always @*
  begin
    rdata_nxt = 32'h0000_0000;
    known_nxt = 1'b1;
    case (paddr)
      `TCCT_CTRL1_ADDR:
      begin
        rdata_nxt[`TCCT_RUN_BIT]  = timer_run_enable_r;
        rdata_nxt[`TCCT_PREC_BIT] = precision_divide_mode_r;
      end
      `TCCT_CTRL2_ADDR:
      begin
        rdata_nxt[`TCCT_OVIE_BIT] = wrap_irq_en_r;
        rdata_nxt[2:0]            = coarse_divide_select_r;
      end
      `TCCT_PDIV_ADDR:   rdata_nxt[7:0]  = precision_divide_value_r;
      `TCCT_DIR_ADDR:    rdata_nxt[1:0]  = channel_direction_bit_r;
      `TCCT_FORCE_ADDR:  rdata_nxt[1:0]  = 2'b00;
      `TCCT_OCMODE_ADDR: rdata_nxt[9:0]  = {compare_mode_bit_r, 6'h00, compare_level_bit_r};
      `TCCT_EDGE_ADDR:   rdata_nxt[9:0]  = {edge_select_high_r, 6'h00, edge_select_low_r};
      `TCCT_IEN_ADDR:    rdata_nxt[1:0]  = channel_irq_enable_r;
      `TCCT_FLAG1_ADDR:  rdata_nxt[1:0]  = channel_event_flag_r;
      `TCCT_FLAG2_ADDR:  rdata_nxt[`TCCT_WRAP_BIT] = counter_wrap_flag_r;
      `TCCT_CNT_ADDR:    rdata_nxt[15:0] = count_r;
      `TCCT_CH0_ADDR:    rdata_nxt[15:0] = chan_val_r[0];
      `TCCT_CH1_ADDR:    rdata_nxt[15:0] = chan_val_r[1];
      `TCCT_DISC_ADDR:   rdata_nxt[1:0]  = pin_disconnect_bit_r;
      `TCCT_PORT_ADDR:   rdata_nxt[9:0]  = {port_dir_r, 6'h00, port_data_r};
      default:           known_nxt = 1'b0;
    endcase
  end

  // Answer registered in setup phase; ready for one access cycle
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~known_nxt;
      if (rd_en)
        prdata <= rdata_nxt;
    end
  end

endmodule // tcct_timer

// *** tb/tcct_pin_model.sv ***
// Model of the external event sources on the capture pins.
// Assumes one-cycle flip requests synchronous to clk.
module tcct_pin_model #(
  parameter int HOLD = 3
) (
  input  logic       clk,
  input  logic [1:0] flip_req,
  output logic [1:0] capture_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] pend_r = 2'h0;
  int         age_r [2] = '{0, 0};
  initial capture_in = 2'h0;
  ////////////////////////////////////////////////////////////
  // Toggle a line on request, each level held past two clocks
  always @(posedge clk)
  begin
    for (int i = 0; i < 2; i++)
    begin
      age_r[i] <= age_r[i] + 1;
      pend_r[i] <= pend_r[i] | flip_req[i];
      if ((pend_r[i] | flip_req[i]) && age_r[i] >= HOLD)
      begin
        capture_in[i] <= ~capture_in[i];
        pend_r[i] <= 1'b0;
        age_r[i] <= 0;
      end
    end
  end
endmodule // tcct_pin_model

// *** tb/tcct_timer_checker.sv ***
// Checker: bus, interrupt and pin-enable relations at the timer ports.
// Assumes binding into tcct_timer; one clock, rst async active high.
module tcct_timer_checker (
  input logic        clk,
  input logic        rst,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic        pready,
  input logic        pslverr,
  input logic [1:0]  capture_in,
  input logic [1:0]  pin_out,
  input logic [1:0]  pin_oe_n,
  input logic [1:0]  channel_irq,
  input logic        wrap_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Completed write transfer
  wire wr_acc = psel & penable & pwrite & pready;
  ////////////////////////////////////////////////////////////
  // Bus answer timing and error reporting
  chk_ready_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  chk_unmapped_err: assert property (psel && !penable && paddr > 12'h038 |=> pslverr)
    else $error("unmapped address not refused");
  chk_mapped_ok: assert property (psel && !penable && paddr < 12'h03c && paddr[1:0] == 2'h0 |=> !pslverr)
    else $error("mapped address refused");
  chk_err_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read not zero");
  ////////////////////////////////////////////////////////////
  // Requests fall and pin enables move only after software writes
  chk_chan_hold: assert property (|($past(channel_irq) & ~channel_irq) |-> $past(wr_acc, 2))
    else $error("channel request dropped without write");
  chk_wrap_hold: assert property ($fell(wrap_irq) |-> $past(wr_acc, 2))
    else $error("wrap request dropped without write");
  chk_oe_write: assert property ($changed(pin_oe_n) |-> $past(wr_acc) || $past(wr_acc, 2))
    else $error("pin enable moved without write");
  // Main scenarios reached
  cov_chan_irq: cover property ($rose(channel_irq[0]));
  cov_wrap_irq: cover property ($rose(wrap_irq));
  cov_refused: cover property (pslverr);
  cov_pin_move: cover property ($changed(pin_out[1]));
endmodule // tcct_timer_checker

bind tcct_timer tcct_timer_checker u_chk (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .capture_in, .pin_out, .pin_oe_n, .channel_irq, .wrap_irq);

// *** tb/tcct_timer_tb.sv ***
// Testbench: register-driven timer scenarios with a capture pin model.
// Assumes design, checker and pin model are compiled before it.
`include "tcct_regs.vh"
module tcct_timer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, c0;
  logic        pready, pslverr, wrap_irq, rise, hit, ex;
  logic [1:0]  capture_in, pin_out, pin_oe_n, channel_irq, k, flip_req = 2'h0;
  logic [1:0]  codes [5] = '{2'h3, 2'h1, 2'h2, 2'h1, 2'h0};
  int          failures = 0, checked = 0, n, v, seed = 32'hdd00ce80;
  always #50 clk = ~clk;
  tcct_timer u_dut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .capture_in, .pin_out, .pin_oe_n, .channel_irq, .wrap_irq);
  tcct_pin_model u_pins (.clk, .flip_req, .capture_in);
  ////////////////////////////////////////////////////////////
  // Verdict and run end
  task automatic end_sim;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge clk);
  endtask
  // One bus transfer, held until ready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int t;
    t = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      t++;
    end
    while (pready !== 1'b1 && t < 20);
    if (t >= 20)
    begin
      failures++;
      end_sim;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  // Counter advance over d cycles
  task automatic rate(input logic [31:0] c1, input logic [31:0] c2, input logic [31:0] pd, input int d, e);
    wr(`TCCT_CTRL1_ADDR, 32'h0);
    wr(`TCCT_CTRL2_ADDR, c2);
    wr(`TCCT_PDIV_ADDR, pd);
    wr(`TCCT_CTRL1_ADDR, c1);
    apb(1'b0, `TCCT_CNT_ADDR, 32'h0);
    c0 = rd;
    tick(d - 3);
    apb(1'b0, `TCCT_CNT_ADDR, 32'h0);
    chk({16'h0, rd[15:0] - c0[15:0]}, e);
  endtask
  ////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    tick(8);
    rst <= 1'b0;
    tick(1);
    rdc(`TCCT_CNT_ADDR, 32'h0);
    rdc(`TCCT_CH0_ADDR, 32'h0);
    rdc(`TCCT_FORCE_ADDR, 32'h0);
    rdc(12'h03c, 32'h0);
    chk(err, 32'h1);
    wr(`TCCT_CTRL2_ADDR, 32'h80);
    wr(`TCCT_CTRL1_ADDR, 32'h80);
    for (n = 0; wrap_irq !== 1'b1 && n < 70000; n++)
      tick(1);
    chk(wrap_irq, 32'h1);
    wr(`TCCT_CTRL1_ADDR, 32'h0);
    wr(`TCCT_FLAG2_ADDR, 32'h80);
    rdc(`TCCT_FLAG2_ADDR, 32'h80);
    apb(1'b0, `TCCT_CNT_ADDR, 32'h0);
    tick(50);
    rdc(`TCCT_CNT_ADDR, rd);
    wr(`TCCT_CTRL1_ADDR, 32'h80);
    wr(`TCCT_FLAG2_ADDR, 32'h80);
    rdc(`TCCT_FLAG2_ADDR, 32'h0);
    tick(3);
    chk(wrap_irq, 32'h0);
    for (int s = 0; s < 8; s++)
      rate(32'h80, s, 32'h0, 1024, 1024 >> s);
    repeat (3)
    begin
      v = $random(seed) & 8'hff;
      rate(32'h88, 32'h0, v, (v + 1) * 4, 4);
    end
    // Capture on channel 0 under every edge mode
    wr(`TCCT_CTRL1_ADDR, 32'h80);
    wr(`TCCT_CTRL2_ADDR, 32'h3);
    wr(`TCCT_IEN_ADDR, 32'h3);
    wr(`TCCT_DIR_ADDR, 32'h2);
    for (int m = 0; m < 4; m++)
    begin
      wr(`TCCT_EDGE_ADDR, {23'h0, m[1], 7'h0, m[0]});
      repeat (2)
      begin
        wr(`TCCT_FLAG1_ADDR, 32'h3);
        apb(1'b0, `TCCT_CNT_ADDR, 32'h0);
        c0 = rd;
        rise = ~capture_in[0];
        flip_req[0] <= 1'b1;
        tick(1);
        flip_req[0] <= 1'b0;
        tick(10);
        hit = rise ? m[0] : m[1];
        rdc(`TCCT_FLAG1_ADDR, {31'h0, hit});
        chk(channel_irq[0], hit);
        apb(1'b0, `TCCT_CH0_ADDR, 32'h0);
        if (hit)
          chk(32'(rd >= c0 && rd <= c0 + 3), 32'h1);
      end
    end
    // Compare actions on channel 1
    foreach (codes[i])
    begin
      k = codes[i];
      wr(`TCCT_OCMODE_ADDR, {22'h0, k[1], 7'h0, k[0], 1'b0});
      wr(`TCCT_FLAG1_ADDR, 32'h3);
      apb(1'b0, `TCCT_CNT_ADDR, 32'h0);
      wr(`TCCT_CH1_ADDR, {16'h0, rd[15:0] + 16'h2 + 16'($random(seed) & 7)});
      tick(100);
      rdc(`TCCT_FLAG1_ADDR, 32'h2);
      chk(channel_irq[1], 32'h1);
      ex = k[1] ? k[0] : ~ex;
      if (k != 2'h0)
        chk(pin_out[1], ex);
      else
        chk(pin_oe_n[1], 32'h1);
    end
    // Preset while disconnected, hand-over, port latch
    wr(`TCCT_FLAG1_ADDR, 32'h3);
    wr(`TCCT_DISC_ADDR, 32'h2);
    wr(`TCCT_OCMODE_ADDR, 32'h202);
    wr(`TCCT_FORCE_ADDR, 32'h2);
    rdc(`TCCT_FLAG1_ADDR, 32'h0);
    wr(`TCCT_PORT_ADDR, 32'h200);
    tick(3);
    chk({pin_oe_n[1], pin_out[1]}, 32'h0);
    wr(`TCCT_DISC_ADDR, 32'h0);
    tick(3);
    chk({pin_oe_n[1], pin_out[1]}, 32'h1);
    wr(`TCCT_OCMODE_ADDR, 32'h200);
    wr(`TCCT_FORCE_ADDR, 32'h2);
    tick(3);
    chk(pin_out[1], 32'h0);
    wr(`TCCT_PORT_ADDR, 32'h202);
    tick(3);
    chk(pin_out[1], 32'h0);
    wr(`TCCT_OCMODE_ADDR, 32'h0);
    tick(3);
    chk(pin_out[1], 32'h1);
    end_sim;
  end
endmodule // tcct_timer_tb
